// *** rtl/bec_params.svh ***
`ifndef BEC_PARAMS_SVH
`define BEC_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index.
`define BEC_IDX_CLR     8'h20
`define BEC_IDX_PORT    8'h21
`define BEC_IDX_START   8'h22
`define BEC_IDX_CRC     8'h23
`define BEC_IDX_RESULT  8'h24
`define BEC_IDX_IRQ_STS 8'h2E
`define BEC_IDX_IRQ_MSK 8'h2F

// Start register mode codes.
`define BEC_MODE_H1     3'h1
`define BEC_MODE_V      3'h2
`define BEC_MODE_H2     3'h4

// Buffer geometry.
`define BEC_LEN_H       9'h022
`define BEC_LEN_V       9'h110
`define BEC_LAST_ADDR   9'h10F

// Horizontal CRC settings.
`define BEC_CRC_POLY    14'h0805
`define BEC_CRC_BYTES   9'h018

// Bit positions and reset values.
`define BEC_RES_H_BIT   7
`define BEC_RST_BYTE    8'h00
`define BEC_RST_CRC     14'h0000

`endif

// *** rtl/bec_pkg.sv ***
package bec_pkg;

  // Sequencer states of the correction engine.
  typedef enum logic [1:0] {
    BEC_IDLE,
    BEC_RUN,
    BEC_DONE
  } bec_state_t;

  // Complete state of the block.
  typedef struct packed {
    logic [271:0][7:0] mem;
    logic [8:0]        cnt;
    logic [8:0]        idx;
    bec_state_t        st;
    logic [2:0]        mode;
    logic [13:0]       crc;
    logic [7:0]        syn;
    logic              crc_err;
    logic [7:0]        res;
    logic              irq_sts;
    logic              irq_msk;
    logic              ack;
    logic [7:0]        rdat;
  } bec_regs_t;

endpackage : bec_pkg

// *** rtl/bec_top.sv ***
// Notes on behaviour
// - Any clear write zeroes buffer address counter.
// - Data port works alike in every mode.
// - Mode code in bits 2..0 starts correction.
// - Code 1 corrects 34-byte received block.
// - Code 2 corrects 272-byte vertical block.
// - Code 4 runs second 34-byte horizontal pass.
// - Completion raises the interrupt.
// - Mode bit reads one until correction ends.
// - Horizontal pass reports 14-bit CRC in bit 0.
// - Starting clears CRC and correction results.
// - Result is error unless syndromes are zero.
// - Horizontal outcome sits in result bit 7.
// - Vertical outcome gives one flag per bit.
`include "bec_params.svh"

module bec_top (
  // Clock and reset.
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  // Wishbone classic slave.
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [9:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Interrupt.
  output logic             o_irq
);
  import bec_pkg::*;

  bec_regs_t   s_q;
  bec_regs_t   s_d;
  logic        take;
  logic        wr;
  logic        rd;
  logic [7:0]  idx_sel;
  logic        wr_clr;
  logic        wr_start;
  logic        acc_port;
  logic        start_ok;
  logic [8:0]  run_len;
  logic [7:0]  run_byte;
  logic [7:0]  port_byte;
  logic        is_vert;

  // Bitwise CRC update of one byte, most significant bit first.
  function automatic logic [13:0] crc_step(input logic [13:0] c,
                                           input logic [7:0]  b);
    logic [13:0] r;
    logic        fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[13] ^ b[i];
      r  = {r[12:0], 1'b0} ^ (fb ? `BEC_CRC_POLY : 14'h0000);
    end
    return r;
  endfunction : crc_step

  // Bus decode; side effects happen on the cycle the request is taken.
  assign take      = i_wb_cyc && i_wb_stb && !s_q.ack;
  assign wr        = take && i_wb_we && i_wb_sel[0];
  assign rd        = take && !i_wb_we;
  assign idx_sel   = i_wb_adr[9:2];
  assign wr_clr    = wr && (idx_sel == `BEC_IDX_CLR);
  assign wr_start  = wr && (idx_sel == `BEC_IDX_START);
  assign acc_port  = (wr || rd) && (idx_sel == `BEC_IDX_PORT);
  assign port_byte = s_q.mem[s_q.cnt];
  assign run_byte  = s_q.mem[s_q.idx];
  assign is_vert   = (s_q.mode == `BEC_MODE_V);
  assign run_len   = is_vert ? `BEC_LEN_V : `BEC_LEN_H;

  // Only a single valid code written while idle starts a correction.
  assign start_ok = wr_start && (s_q.st == BEC_IDLE) &&
                    ((i_wb_dat[2:0] == `BEC_MODE_H1) ||
                     (i_wb_dat[2:0] == `BEC_MODE_V)  ||
                     (i_wb_dat[2:0] == `BEC_MODE_H2));

  // Next-state logic for bus slave, buffer and correction engine.
  always_comb begin
    s_d     = s_q;
    s_d.ack = take;
    // Reads are captured in a register so data stands after the ack.
    if (rd) begin
      unique case (idx_sel)
        `BEC_IDX_PORT:    s_d.rdat = port_byte;
        `BEC_IDX_START:   s_d.rdat = {5'h00, s_q.mode};
        `BEC_IDX_CRC:     s_d.rdat = {7'h00, s_q.crc_err};
        `BEC_IDX_RESULT:  s_d.rdat = s_q.res;
        `BEC_IDX_IRQ_STS: s_d.rdat = {7'h00, s_q.irq_sts};
        `BEC_IDX_IRQ_MSK: s_d.rdat = {7'h00, s_q.irq_msk};
        default:          s_d.rdat = `BEC_RST_BYTE;
      endcase
    end
    // The transfer port ignores the mode entirely.
    if (acc_port) begin
      if (wr) begin
        s_d.mem[s_q.cnt] = i_wb_dat[7:0];
      end
      if (s_q.cnt == `BEC_LAST_ADDR) begin
        s_d.cnt = 9'd0;
      end else begin
        s_d.cnt = s_q.cnt + 9'd1;
      end
    end
    // A clear taken with a port access in the same cycle wins.
    if (wr_clr) begin
      s_d.cnt = 9'd0;
    end
    if (wr && (idx_sel == `BEC_IDX_IRQ_MSK)) begin
      s_d.irq_msk = i_wb_dat[0];
    end
    if (rd && (idx_sel == `BEC_IDX_IRQ_STS)) begin
      s_d.irq_sts = 1'b0;
    end
    // The engine comes after the status clear, so a completion set wins.
    unique case (s_q.st)
      BEC_IDLE: begin
        if (start_ok) begin
          s_d.st      = BEC_RUN;
          s_d.mode    = i_wb_dat[2:0];
          s_d.idx     = 9'd0;
          s_d.crc     = `BEC_RST_CRC;
          s_d.syn     = `BEC_RST_BYTE;
          s_d.crc_err = 1'b0;
          s_d.res     = `BEC_RST_BYTE;
        end
      end
      BEC_RUN: begin
        // One byte per cycle from address zero; data is written back.
        s_d.mem[s_q.idx] = run_byte;
        s_d.syn = s_q.syn ^ run_byte;
        if (!is_vert && (s_q.idx < `BEC_CRC_BYTES)) begin
          s_d.crc = crc_step(s_q.crc, run_byte);
        end
        if (s_q.idx == run_len - 9'd1) begin
          s_d.st = BEC_DONE;
        end else begin
          s_d.idx = s_q.idx + 9'd1;
        end
      end
      BEC_DONE: begin
        if (is_vert) begin
          s_d.res = s_q.syn;
        end else begin
          s_d.res = `BEC_RST_BYTE;
          s_d.res[`BEC_RES_H_BIT] = (s_q.syn != 8'h00);
          s_d.crc_err = (s_q.crc != `BEC_RST_CRC);
        end
        s_d.mode    = 3'h0;
        s_d.irq_sts = 1'b1;
        s_d.st      = BEC_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from state.
  assign o_wb_ack = s_q.ack;
  assign o_wb_dat = {24'h000000, s_q.rdat};
  assign o_irq    = s_q.irq_sts && s_q.irq_msk;

  // Helpers for the checks below.
  logic start_h1;
  logic start_v;
  logic start_h2;
  assign start_h1 = start_ok && (i_wb_dat[2:0] == `BEC_MODE_H1);
  assign start_v  = start_ok && (i_wb_dat[2:0] == `BEC_MODE_V);
  assign start_h2 = start_ok && (i_wb_dat[2:0] == `BEC_MODE_H2);

  // The checks below sample on the bus clock and rest during reset.
  // They watch state, outputs and the host requests decoded from the bus.
  // A clear write leaves the counter at zero.
  AST_CLR_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    wr_clr |=> (s_q.cnt == 9'd0))
    else $error("Counter not cleared by clear write.");

  // Port access steps the counter by one.
  AST_PORT_STEP: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (acc_port && !wr_clr && (s_q.cnt < `BEC_LAST_ADDR))
      |=> (s_q.cnt == $past(s_q.cnt) + 9'd1))
    else $error("Port access did not advance the counter.");

  // A port read returns the byte at the counter.
  AST_PORT_READ: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (rd && (idx_sel == `BEC_IDX_PORT))
      |=> (o_wb_ack && (o_wb_dat[7:0] == $past(port_byte))))
    else $error("Port read returned the wrong byte.");

  // First horizontal pass: busy 35 cycles then idle.
  AST_H1_BUSY: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    start_h1 |=> (s_q.mode == `BEC_MODE_H1) ##34
      (s_q.mode == `BEC_MODE_H1) ##1 (s_q.mode == 3'h0))
    else $error("Horizontal pass length wrong.");

  // Vertical pass: busy 273 cycles then idle.
  AST_V_BUSY: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    start_v |=> (s_q.mode == `BEC_MODE_V) ##272
      (s_q.mode == `BEC_MODE_V) ##1 (s_q.mode == 3'h0))
    else $error("Vertical pass length wrong.");

  // Second horizontal pass: same length as the first.
  AST_H2_BUSY: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    start_h2 |=> (s_q.mode == `BEC_MODE_H2) ##34
      (s_q.mode == `BEC_MODE_H2) ##1 (s_q.mode == 3'h0))
    else $error("Second horizontal pass length wrong.");

  // A start goes busy and ends within the longest pass.
  AST_START_RUN: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    start_ok |=> (s_q.st == BEC_RUN) ##[1:274] (s_q.st == BEC_IDLE))
    else $error("Started correction did not run and finish.");

  // Completion sets the sticky interrupt flag.
  AST_DONE_IRQ: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (s_q.st == BEC_DONE) |=> s_q.irq_sts)
    else $error("Completion did not set the interrupt.");

  // Mode bit reads as one while the engine runs.
  AST_MODE_SHOW: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (s_q.st == BEC_RUN) |-> (s_q.mode != 3'h0))
    else $error("Running engine shows no mode bit.");

  // Starting clears both result registers.
  AST_START_CLR: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    start_ok |=> ((s_q.res == 8'h00) && !s_q.crc_err))
    else $error("Results not cleared at start.");

  // Horizontal CRC flag follows the final remainder.
  AST_CRC_FLAG: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ((s_q.st == BEC_DONE) && !is_vert)
      |=> (s_q.crc_err == ($past(s_q.crc) != 14'h0000)))
    else $error("CRC flag does not match the remainder.");

  // Horizontal outcome in bit 7 only.
  AST_H_RESULT: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ((s_q.st == BEC_DONE) && !is_vert)
      |=> (s_q.res == {($past(s_q.syn) != 8'h00), 7'h00}))
    else $error("Horizontal result wrong.");

  // Vertical outcome one flag per bit lane.
  AST_V_RESULT: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ((s_q.st == BEC_DONE) && is_vert)
      |=> (s_q.res == $past(s_q.syn)))
    else $error("Vertical result wrong.");

  // Ack is a single-cycle pulse for every request taken.
  AST_ACK_PULSE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    take |=> (o_wb_ack ##1 !o_wb_ack))
    else $error("Bus acknowledge is not a one-cycle pulse.");

  // A port write lands at the location the counter pointed to.
  AST_PORT_WRITE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (wr && (idx_sel == `BEC_IDX_PORT))
      |=> (s_q.mem[$past(s_q.cnt)] == $past(i_wb_dat[7:0])))
    else $error("Port write did not land in the buffer.");

  // The counter wraps from the last location back to zero.
  AST_CNT_WRAP: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (acc_port && (s_q.cnt == `BEC_LAST_ADDR))
      |=> (s_q.cnt == 9'h000))
    else $error("Counter did not wrap after the last location.");

  // The counter never points past the buffer.
  AST_CNT_RANGE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_q.cnt <= `BEC_LAST_ADDR)
    else $error("Counter left the buffer range.");

  // A start refused for its code leaves the engine idle.
  AST_BAD_CODE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (wr_start && (s_q.st == BEC_IDLE) && !start_ok)
      |=> ((s_q.st == BEC_IDLE) && (s_q.mode == 3'h0)))
    else $error("Invalid mode code started the engine.");

  // A start written while running disturbs nothing.
  AST_BUSY_START: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (wr_start && (s_q.st == BEC_RUN))
      |=> ($stable(s_q.mode) && $stable(s_q.res)))
    else $error("Start while busy disturbed the engine.");

  // Exactly one mode bit shows while the engine runs.
  AST_MODE_ONE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (s_q.st == BEC_RUN) |-> $onehot(s_q.mode))
    else $error("Running engine shows no single mode bit.");

  // The engine walks the buffer only within the pass length.
  AST_IDX_RANGE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (s_q.st == BEC_RUN) |-> (s_q.idx < run_len))
    else $error("Engine index ran past the pass length.");

  // Each engine step stores the corrected byte back in place.
  AST_WRITE_BACK: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (s_q.st == BEC_RUN)
      |=> (s_q.mem[$past(s_q.idx)] == $past(run_byte)))
    else $error("Engine did not store the byte back in place.");

  // A vertical pass leaves the CRC flag normal.
  AST_V_NO_CRC: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ((s_q.st == BEC_DONE) && is_vert) |=> !s_q.crc_err)
    else $error("Vertical pass set the CRC flag.");

  // Results stand unchanged until the next start.
  AST_RES_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ((s_q.st == BEC_IDLE) && !start_ok)
      |=> ($stable(s_q.res) && $stable(s_q.crc_err)))
    else $error("Results changed without a new pass.");

  // The status flag stays set until a status read.
  AST_IRQ_STICKY: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (s_q.irq_sts && !(rd && (idx_sel == `BEC_IDX_IRQ_STS)))
      |=> s_q.irq_sts)
    else $error("Interrupt status dropped without a read.");

  // A status read clears the flag unless a pass completes then.
  AST_IRQ_CLEAR: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (rd && (idx_sel == `BEC_IDX_IRQ_STS) && (s_q.st != BEC_DONE))
      |=> !s_q.irq_sts)
    else $error("Status read did not clear the interrupt.");

  // Read data stands until the next read is taken.
  AST_RDAT_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !rd |=> $stable(o_wb_dat))
    else $error("Read data changed without a read.");

  // The interrupt output stays quiet while the mask is clear.
  AST_IRQ_MASKED: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !s_q.irq_msk |-> !o_irq)
    else $error("Masked interrupt reached the output.");

  // A pass begins its walk at location zero.
  AST_START_IDX: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    start_ok |=> (s_q.idx == 9'h000))
    else $error("Pass did not start at location zero.");

  // An unmasked completion raises the interrupt output.
  AST_IRQ_OUT: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ((s_q.st == BEC_DONE) && s_q.irq_msk &&
     !(wr && (idx_sel == `BEC_IDX_IRQ_MSK)))
      |=> o_irq)
    else $error("Unmasked completion did not raise the interrupt.");

  // The CRC only moves over the leading bytes of a horizontal pass.
  AST_CRC_SPAN: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ((s_q.st == BEC_RUN) && (is_vert || (s_q.idx >= `BEC_CRC_BYTES)))
      |=> $stable(s_q.crc))
    else $error("CRC changed outside its byte span.");

  // Completion returns the engine to idle with the mode bits cleared.
  AST_DONE_IDLE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (s_q.st == BEC_DONE)
      |=> ((s_q.st == BEC_IDLE) && (s_q.mode == 3'h0)))
    else $error("Engine did not return to idle after completion.");

  // Main scenarios.
  COV_H1: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    start_h1 ##[1:40] (s_q.st == BEC_DONE));
  COV_V: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    start_v ##[1:280] (s_q.st == BEC_DONE));
  COV_H2: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    start_h2 ##[1:40] (s_q.st == BEC_DONE));
  COV_IRQ: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    o_irq);
  COV_WRAP: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    acc_port && (s_q.cnt == `BEC_LAST_ADDR));

endmodule : bec_top

// *** test/bec_host.sv ***
`include "bec_params.svh"

module bec_host (
  // Clock.
  input  wire logic        i_ref_clk,
  // Wishbone classic master side.
  output logic             o_cyc,
  output logic             o_stb,
  output logic             o_we,
  output logic [9:0]       o_adr,
  output logic [3:0]       o_sel,
  output logic [31:0]      o_dat,
  input  wire logic [31:0] i_dat,
  input  wire logic        i_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bus idles low from time zero; only the low byte lane is used.
  initial begin
    {o_cyc, o_stb, o_we, o_adr, o_dat} = '0;
  end
  assign o_sel = 4'h1;

  // One classic cycle, held until ack is sampled high at a rising edge.
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd);
    @(posedge i_ref_clk);
    {o_cyc, o_stb, o_we} <= {2'b11, wr};
    o_adr <= {idx, 2'b00};
    o_dat <= {24'h000000, wd};
    do @(posedge i_ref_clk); while (i_ack !== 1'b1);
    rd = i_dat[7:0];
    {o_cyc, o_stb} <= 2'b00;
  endtask : xfer

  // Clear the counter, then stream a whole code word in.
  task automatic load(input logic [7:0] q[$]);
    logic [7:0] d;
    xfer(1'b1, `BEC_IDX_CLR, 8'h00, d);
    foreach (q[i]) xfer(1'b1, `BEC_IDX_PORT, q[i], d);
  endtask : load

  // Clear the counter again, then fetch the corrected word.
  task automatic unload(input int n, output logic [7:0] q[$]);
    logic [7:0] d;
    q = {};
    xfer(1'b1, `BEC_IDX_CLR, 8'hA5, d);
    repeat (n) begin
      xfer(1'b0, `BEC_IDX_PORT, 8'h00, d);
      q.push_back(d);
    end
  endtask : unload
endmodule : bec_host

// *** test/block_error_correction_control_tb.sv ***
`include "bec_params.svh"

module block_error_correction_control_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_ref_clk;
  logic        i_reset;
  logic        cyc, stb, we, ack, irq;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [31:0] seed = 32'h22DE;
  logic [7:0]  wq[$], rq[$];
  logic [7:0]  d, syn;
  logic [2:0]  codes[3];
  logic        msk, crc_bit;
  int          n, k, errors, tests_run;

  bec_host host (.i_ref_clk(i_ref_clk), .o_cyc(cyc), .o_stb(stb),
    .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat), .i_dat(rdat),
    .i_ack(ack));
  bec_top DUT (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq));

  // Free-running 250 MHz clock.
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  // Xorshift source for the code word bytes.
  function automatic logic [7:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : next_rand

  // Reference CRC-14 over the first 24 bytes, MSB first, zero start.
  function automatic logic [13:0] crc14(input logic [7:0] q[$]);
    logic [13:0] c;
    c = 14'h0000;
    for (int i = 0; i < 24; i++)
      for (int b = 7; b >= 0; b--)
        c = {c[12:0], 1'b0} ^ ((c[13] ^ q[i][b]) ? `BEC_CRC_POLY : 14'h0);
    return c;
  endfunction : crc14

  // Compare and count.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Register read with comparison.
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    host.xfer(1'b0, idx, 8'h00, v);
    chk(v, exp);
  endtask : rd

  // Verdict and end of run.
  task automatic conclude;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // Hang guard well beyond the expected run length.
  initial begin
    #200000;
    errors++;
    conclude();
  end

  // Main sequence: reset state, then one full pass per mode.
  initial begin
    codes = '{`BEC_MODE_H1, `BEC_MODE_V, `BEC_MODE_H2};
    msk = 1'b0;
    i_reset = 1'b1;
    repeat (8) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    rd(`BEC_IDX_START, 8'h00);
    rd(`BEC_IDX_CRC, 8'h00);
    rd(`BEC_IDX_RESULT, 8'h00);
    rd(8'h10, 8'h00);
    host.xfer(1'b1, `BEC_IDX_START, 8'h03, d);
    rd(`BEC_IDX_START, 8'h00);
    foreach (codes[m]) begin
      n = (codes[m] == `BEC_MODE_V) ? 272 : 34;
      wq = {};
      syn = 8'h00;
      for (int i = 0; i < n; i++) begin
        d = (m == 2 && i == n - 1) ? syn : next_rand();
        syn ^= d;
        wq.push_back(d);
      end
      // Stray bytes first: the clear inside load must discard them.
      repeat (3) host.xfer(1'b1, `BEC_IDX_PORT, 8'hEE, d);
      host.load(wq);
      host.xfer(1'b1, `BEC_IDX_START, {5'h00, codes[m]}, d);
      rd(`BEC_IDX_START, {5'h00, codes[m]});
      rd(`BEC_IDX_CRC, 8'h00);
      rd(`BEC_IDX_RESULT, 8'h00);
      // A second start while busy is ignored.
      host.xfer(1'b1, `BEC_IDX_START, {5'h00, codes[(m + 1) % 3]}, d);
      rd(`BEC_IDX_START, {5'h00, codes[m]});
      k = 0;
      do begin
        host.xfer(1'b0, `BEC_IDX_START, 8'h00, d);
        k++;
      end while (d !== 8'h00 && k < 400);
      chk(d, 8'h00);
      chk({7'h00, irq}, {7'h00, msk});
      host.xfer(1'b1, `BEC_IDX_IRQ_MSK, 8'h01, d);
      msk = 1'b1;
      chk({7'h00, irq}, 8'h01);
      rd(`BEC_IDX_IRQ_MSK, 8'h01);
      rd(`BEC_IDX_IRQ_STS, 8'h01);
      chk({7'h00, irq}, 8'h00);
      crc_bit = (n == 34) && (crc14(wq) != 14'h0);
      rd(`BEC_IDX_CRC, {7'h00, crc_bit});
      rd(`BEC_IDX_RESULT, (n == 34) ? {syn != 0, 7'h00} : syn);
      host.unload(n, rq);
      foreach (rq[i]) chk(rq[i], wq[i]);
    end
    conclude();
  end
endmodule : block_error_correction_control_tb
